// File: include/tpwm_pkg.sv
package tpwm_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_COMPARE = 8'h54;
  localparam logic [7:0] OFS_DEADTIME = 8'h58;
  localparam logic [7:0] OFS_COUNTER = 8'h5C;
  localparam logic [7:0] OFS_PERIOD = 8'h40;
  localparam logic [7:0] OFS_PRESCALE = 8'h44;
  localparam logic [7:0] OFS_MODE = 8'h48;
  localparam logic [7:0] OFS_LOCK = 8'h4C;
  localparam logic [7:0] OFS_INT_STATUS = 8'h60;
  localparam logic [7:0] OFS_INT_MASK = 8'h64;
  // field positions
  localparam int DT_CLKSEL_BIT = 24;
  localparam int DT_ENABLE_BIT = 16;
  localparam int DT_LEN_MSB = 11;
  localparam int DIR_FLAG_BIT = 16;
  localparam int MODE_CMPL_BIT = 2;
  localparam int INT_ZERO_BIT = 0;
  localparam int INT_PERIOD_BIT = 1;
  localparam int INT_CMP_UP_BIT = 2;
  localparam int INT_CMP_DN_BIT = 3;
  localparam int INT_WIDTH = 4;
  // reset values
  localparam logic [15:0] COMPARE_RST = 16'h0000;
  localparam logic [31:0] DEADTIME_RST = 32'h0000_0000;
  localparam logic [15:0] PERIOD_RST = 16'h0000;
  localparam logic [11:0] PRESCALE_RST = 12'h000;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [3:0] INT_MASK_RST = 4'h0;
  // unlock key sequence written to the lock register
  localparam logic [7:0] UNLOCK_KEY1 = 8'h59;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h16;
  localparam logic [7:0] UNLOCK_KEY3 = 8'h88;
  // count types
  typedef enum logic [1:0] {
    TPWM_CNT_UP = 2'b00,
    TPWM_CNT_DOWN = 2'b01,
    TPWM_CNT_UPDOWN = 2'b10
  } tpwm_count_type;
endpackage

// File: hw/tpwm_counter.sv
`timescale 1ns/1ps
module tpwm_counter #(
  parameter int CNT_W = 16,
  parameter int PSC_W = 12
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [CNT_W-1:0] period,
  input wire logic [PSC_W-1:0] prescale_divider,
  input wire logic [1:0] count_type,
  output logic [CNT_W-1:0] live_count_value,
  output logic count_direction_flag,
  output logic tick
);
  initial
  begin
    if (CNT_W < 2 || PSC_W < 1)
    begin
      $error("tpwm_counter: widths too small");
    end
  end
  typedef struct packed {
    logic [PSC_W-1:0] psc;
    logic [CNT_W-1:0] cnt;
    logic up;
    logic tick;
  } tpwm_cnt_state_type;
  tpwm_cnt_state_type s_r;
  tpwm_cnt_state_type s_nxt;
  // prescaled tick and three count types
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.psc >= prescale_divider)
    begin
      s_nxt.psc = '0;
      s_nxt.tick = 1'b1;
      case (count_type)
        2'b00:
        begin
          s_nxt.up = 1'b1;
          s_nxt.cnt = (s_r.cnt >= period) ? '0 : s_r.cnt + 1'b1;
        end
        2'b01:
        begin
          s_nxt.up = 1'b0;
          s_nxt.cnt = (s_r.cnt == '0 || s_r.cnt > period) ? period : s_r.cnt - 1'b1;
        end
        2'b10:
        begin
          if (s_r.up)
          begin
            if (s_r.cnt >= period)
            begin
              s_nxt.up = 1'b0;
              s_nxt.cnt = (period == '0) ? '0 : period - 1'b1;
            end
            else
            begin
              s_nxt.cnt = s_r.cnt + 1'b1;
            end
          end
          else if (s_r.cnt == '0)
          begin
            s_nxt.up = 1'b1;
            s_nxt.cnt = (period == '0) ? '0 : CNT_W'(1);
          end
          else
          begin
            s_nxt.cnt = s_r.cnt - 1'b1;
          end
        end
        default:
        begin
          s_nxt.up = 1'b1;
          s_nxt.cnt = '0;
        end
      endcase
    end
    else
    begin
      s_nxt.psc = s_r.psc + 1'b1;
    end
  end
  // state register
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_r <= '{psc: '0, cnt: '0, up: 1'b1, tick: 1'b0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  assign live_count_value = s_r.cnt;
  assign count_direction_flag = s_r.up;
  assign tick = s_r.tick;
endmodule

// File: hw/tpwm_deadtime.sv
`timescale 1ns/1ps
module tpwm_deadtime #(
  parameter int LEN_W = 12
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic raw_wave,
  input wire logic complementary,
  input wire logic insert_enable,
  input wire logic clock_select,
  input wire logic prescale_tick,
  input wire logic [LEN_W-1:0] deadtime_length,
  output logic out_a,
  output logic out_b
);
  initial
  begin
    if (LEN_W < 1)
    begin
      $error("tpwm_deadtime: width too small");
    end
  end
  typedef struct packed {
    logic prev;
    logic busy;
    logic [LEN_W:0] left;
    logic a;
    logic b;
  } tpwm_dt_state_type;
  tpwm_dt_state_type s_r;
  tpwm_dt_state_type s_nxt;
  logic step;
  // dead-time step: plain clock or prescaled tick
  assign step = clock_select ? prescale_tick : 1'b1;
  // complementary pair with rising edges delayed
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.prev = raw_wave;
    if (!complementary)
    begin
      s_nxt.busy = 1'b0;
      s_nxt.a = raw_wave;
      s_nxt.b = 1'b0;
    end
    else if (!insert_enable)
    begin
      s_nxt.busy = 1'b0;
      s_nxt.a = raw_wave;
      s_nxt.b = ~raw_wave;
    end
    else if (raw_wave != s_r.prev)
    begin
      s_nxt.a = 1'b0;
      s_nxt.b = 1'b0;
      s_nxt.busy = 1'b1;
      s_nxt.left = {1'b0, deadtime_length} + 1'b1;
    end
    else if (s_r.busy)
    begin
      if (step)
      begin
        if (s_r.left <= (LEN_W+1)'(1))
        begin
          s_nxt.busy = 1'b0;
          s_nxt.a = raw_wave;
          s_nxt.b = ~raw_wave;
        end
        else
        begin
          s_nxt.left = s_r.left - 1'b1;
        end
      end
    end
    else
    begin
      s_nxt.a = raw_wave;
      s_nxt.b = ~raw_wave;
    end
  end
  // state register
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
  assign out_a = s_r.a;
  assign out_b = s_r.b;
endmodule

// File: hw/tpwm_top.sv
// Behaviour
// - compare value against counter shapes wave, events
// - clock select picks plain or prescaled dead-time
// - enable bit turns dead-time on for pair
// - dead-time only in complementary mode
// - complementary mode without dead-time: outputs are exact complements
// - select 0: length plus one source clocks
// - select 1: times prescale divider plus one
// - dead-time fields writable only when unlocked
// - direction flag reads 1 counting up
// - live count readable in low sixteen bits
// - up, down and up-down count types
// - counter clock is source over prescale plus one
`timescale 1ns/1ps
module tpwm_top #(
  parameter int CNT_W = 16,
  parameter int PSC_W = 12,
  parameter int LEN_W = 12
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic pwm_output_a,
  output logic pwm_output_b,
  output logic adc_trigger,
  output logic irq
);
  initial
  begin
    if (CNT_W != 16 || PSC_W > 16 || LEN_W != 12)
    begin
      $error("tpwm_top: unsupported widths");
    end
  end

  typedef struct packed {
    logic [15:0] compare_value;
    logic deadtime_clock_select;
    logic deadtime_insert_enable;
    logic [11:0] deadtime_length;
    logic [15:0] period;
    logic [PSC_W-1:0] prescale_divider;
    logic [2:0] mode;
    logic [1:0] lock_step;
    logic unlocked;
    logic [tpwm_pkg::INT_WIDTH-1:0] int_status;
    logic [tpwm_pkg::INT_WIDTH-1:0] int_mask;
    logic [31:0] rdata;
    logic ack;
    logic wave;
    logic adc;
    logic irq;
    logic out_a;
    logic out_b;
  } tpwm_top_state_type;

  tpwm_top_state_type s_r;
  tpwm_top_state_type s_nxt;
  logic [15:0] live_count_value;
  logic count_direction_flag;
  logic cnt_tick;
  logic dt_a;
  logic dt_b;
  logic bus_req;
  logic wr_en;
  logic rd_en;
  logic [tpwm_pkg::INT_WIDTH-1:0] events;

  // register map, byte offsets on the local bus:
  //   compare value      16 bits, byte lanes honoured
  //   dead-time control  clock select, enable, length; writable only when unlocked
  //   counter readback   direction flag over live count, read only
  //   period             16 bits, top of the count range
  //   prescale           divider for the counter tick
  //   mode               count type in the low two bits, complementary pair above
  //   lock               three keys in a row unlock, any other byte relocks
  //   event status       sticky, cleared by a read, a new event wins
  //   event mask         lane 0 only, same layout as the status
  // unmapped offsets read as zero and ignore writes
  //
  // timing, seen from the bus:
  //   a request is taken on the edge where cyc and stb are high and ack is low
  //   ack and read data stand for exactly the following cycle
  //   the cycle in which ack stands takes no request, so a held strobe is not taken twice
  //
  // the pair outputs lag the internal wave by two registers; the dead-time
  // stage works on the wave as it leaves the register file

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  tpwm_counter #(
    .CNT_W(CNT_W),
    .PSC_W(PSC_W)
  ) u_counter (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .period(s_r.period),
    .prescale_divider(s_r.prescale_divider),
    .count_type(s_r.mode[1:0]),
    .live_count_value(live_count_value),
    .count_direction_flag(count_direction_flag),
    .tick(cnt_tick)
  );

  tpwm_deadtime #(
    .LEN_W(LEN_W)
  ) u_deadtime (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .raw_wave(s_r.wave),
    .complementary(s_r.mode[tpwm_pkg::MODE_CMPL_BIT]),
    .insert_enable(s_r.deadtime_insert_enable),
    .clock_select(s_r.deadtime_clock_select),
    .prescale_tick(cnt_tick),
    .deadtime_length(s_r.deadtime_length),
    .out_a(dt_a),
    .out_b(dt_b)
  );

  // single-cycle classic handshake, ack drops after one cycle
  // the ack register itself blocks the request in its own cycle, which keeps
  // a master that releases only after seeing ack from writing a register twice
  assign bus_req = wb_cyc_i && wb_stb_i && !s_r.ack;
  assign wr_en = bus_req && wb_we_i;
  assign rd_en = bus_req && !wb_we_i;

  // counter events sampled on each counter tick
  // a zero period parks the counter on one value; it then raises no events,
  // so the trigger and the status bits do not stick high out of reset
  always_comb
  begin
    logic run;
    run = cnt_tick && (s_r.period != 16'h0000);
    events = '0;
    // counter at the bottom of its range
    events[tpwm_pkg::INT_ZERO_BIT] = run && (live_count_value == 16'h0000);
    // counter at the top of its range
    events[tpwm_pkg::INT_PERIOD_BIT] = run && (live_count_value == s_r.period);
    // compare match, split by counting direction
    events[tpwm_pkg::INT_CMP_UP_BIT] = run && (live_count_value == s_r.compare_value) && count_direction_flag;
    events[tpwm_pkg::INT_CMP_DN_BIT] = run && (live_count_value == s_r.compare_value) && !count_direction_flag;
  end

  // register file, lock, waveform, events
  always_comb
  begin
    logic [31:0] w;
    w = 32'h0000_0000;
    s_nxt = s_r;
    s_nxt.ack = bus_req;
    s_nxt.rdata = 32'h0000_0000;
    // waveform high while count below compare
    s_nxt.wave = (live_count_value < s_r.compare_value);
    s_nxt.adc = events[tpwm_pkg::INT_CMP_UP_BIT] | events[tpwm_pkg::INT_CMP_DN_BIT];
    // writes
    if (wr_en)
    begin
      case (wb_adr_i)
        tpwm_pkg::OFS_COMPARE:
        begin
          w = lane_merge({16'h0000, s_r.compare_value}, wb_dat_i, wb_sel_i);
          s_nxt.compare_value = w[15:0];
        end
        tpwm_pkg::OFS_DEADTIME:
        begin
          if (s_r.unlocked)
          begin
            w = lane_merge({7'h00, s_r.deadtime_clock_select, 7'h00, s_r.deadtime_insert_enable,
                            4'h0, s_r.deadtime_length}, wb_dat_i, wb_sel_i);
            s_nxt.deadtime_clock_select = w[tpwm_pkg::DT_CLKSEL_BIT];
            s_nxt.deadtime_insert_enable = w[tpwm_pkg::DT_ENABLE_BIT];
            s_nxt.deadtime_length = w[tpwm_pkg::DT_LEN_MSB:0];
          end
        end
        tpwm_pkg::OFS_PERIOD:
        begin
          w = lane_merge({16'h0000, s_r.period}, wb_dat_i, wb_sel_i);
          s_nxt.period = w[15:0];
        end
        tpwm_pkg::OFS_PRESCALE:
        begin
          w = lane_merge({{(32-PSC_W){1'b0}}, s_r.prescale_divider}, wb_dat_i, wb_sel_i);
          s_nxt.prescale_divider = w[PSC_W-1:0];
        end
        tpwm_pkg::OFS_MODE:
        begin
          w = lane_merge({29'h0000_0000, s_r.mode}, wb_dat_i, wb_sel_i);
          s_nxt.mode = w[2:0];
        end
        tpwm_pkg::OFS_LOCK:
        begin
          // three-key unlock; any other byte relocks
          if (wb_sel_i[0])
          begin
            if (s_r.lock_step == 2'h0 && wb_dat_i[7:0] == tpwm_pkg::UNLOCK_KEY1)
            begin
              s_nxt.lock_step = 2'h1;
            end
            else if (s_r.lock_step == 2'h1 && wb_dat_i[7:0] == tpwm_pkg::UNLOCK_KEY2)
            begin
              s_nxt.lock_step = 2'h2;
            end
            else if (s_r.lock_step == 2'h2 && wb_dat_i[7:0] == tpwm_pkg::UNLOCK_KEY3)
            begin
              s_nxt.lock_step = 2'h0;
              s_nxt.unlocked = 1'b1;
            end
            else
            begin
              s_nxt.lock_step = 2'h0;
              s_nxt.unlocked = 1'b0;
            end
          end
        end
        tpwm_pkg::OFS_INT_MASK:
        begin
          if (wb_sel_i[0])
          begin
            s_nxt.int_mask = wb_dat_i[tpwm_pkg::INT_WIDTH-1:0];
          end
        end
        default:
        begin
          w = 32'h0000_0000;
        end
      endcase
    end
    // reads
    // read data is zero outside an answer, so the bus can be or-ed with others
    if (rd_en)
    begin
      case (wb_adr_i)
        tpwm_pkg::OFS_COMPARE: s_nxt.rdata = {16'h0000, s_r.compare_value};
        tpwm_pkg::OFS_DEADTIME: s_nxt.rdata = {7'h00, s_r.deadtime_clock_select, 7'h00,
                                               s_r.deadtime_insert_enable, 4'h0, s_r.deadtime_length};
        tpwm_pkg::OFS_COUNTER: s_nxt.rdata = {15'h0000, count_direction_flag, live_count_value};
        tpwm_pkg::OFS_PERIOD: s_nxt.rdata = {16'h0000, s_r.period};
        tpwm_pkg::OFS_PRESCALE: s_nxt.rdata = {{(32-PSC_W){1'b0}}, s_r.prescale_divider};
        tpwm_pkg::OFS_MODE: s_nxt.rdata = {29'h0000_0000, s_r.mode};
        tpwm_pkg::OFS_LOCK: s_nxt.rdata = {31'h0000_0000, s_r.unlocked};
        tpwm_pkg::OFS_INT_STATUS: s_nxt.rdata = {28'h000_0000, s_r.int_status};
        tpwm_pkg::OFS_INT_MASK: s_nxt.rdata = {28'h000_0000, s_r.int_mask};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // read clears status; a new event in the same cycle wins
    if (rd_en && wb_adr_i == tpwm_pkg::OFS_INT_STATUS)
    begin
      s_nxt.int_status = events;
    end
    else
    begin
      s_nxt.int_status = s_r.int_status | events;
    end
    // level interrupt follows the next status and mask, so it lands with them
    s_nxt.irq = |(s_nxt.int_status & s_nxt.int_mask);
    // pair outputs registered once more so every top output leaves a flip-flop
    s_nxt.out_a = dt_a;
    s_nxt.out_b = dt_b;
  end

  // state register
  // reset leaves the lock closed, the counter parked and every output low
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_r <= '0;
      s_r.compare_value <= tpwm_pkg::COMPARE_RST;
      s_r.period <= tpwm_pkg::PERIOD_RST;
      s_r.prescale_divider <= PSC_W'(tpwm_pkg::PRESCALE_RST);
      s_r.mode <= tpwm_pkg::MODE_RST;
      s_r.int_mask <= tpwm_pkg::INT_MASK_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign wb_dat_o = s_r.rdata;
  assign wb_ack_o = s_r.ack;
  assign pwm_output_a = s_r.out_a;
  assign pwm_output_b = s_r.out_b;
  assign adc_trigger = s_r.adc;
  assign irq = s_r.irq;
endmodule

// File: verif/tpwm_assertions.sv
`timescale 1ns/1ps
module tpwm_assertions (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic pwm_output_a,
  input wire logic pwm_output_b,
  input wire logic adc_trigger
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // a taken request and its single-cycle answer
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  // read of a given register answered this cycle
  sequence s_rd(logic [7:0] ofs);
    wb_ack_o && $past(wb_adr_i) == ofs && !$past(wb_we_i);
  endsequence
  chk_ack_latency: assert property (s_req |=> s_ans) else $error("ack not one cycle after request");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  chk_cnt_reserved: assert property (s_rd(8'h5C) |-> wb_dat_o[31:17] == 15'h0000)
    else $error("counter upper bits set");
  chk_cmp_reserved: assert property (s_rd(8'h54) |-> wb_dat_o[31:16] == 16'h0000)
    else $error("compare upper bits set");
  chk_dt_reserved: assert property (s_rd(8'h58) |-> wb_dat_o[31:25] == 7'h00 && wb_dat_o[23:17] == 7'h00)
    else $error("deadtime reserved bits set");
  chk_pair_apart: assert property (!(pwm_output_a && pwm_output_b)) else $error("both outputs high");
  chk_trig_pulse: assert property (adc_trigger |=> !adc_trigger) else $error("trigger longer than a cycle");
endmodule
bind tpwm_top tpwm_assertions u_chk (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pwm_output_a(pwm_output_a), .pwm_output_b(pwm_output_b), .adc_trigger(adc_trigger));

// File: verif/tpwm_partner.sv
`timescale 1ns/1ps
module tpwm_partner (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic pwm_output_a,
  input wire logic pwm_output_b,
  input wire logic adc_trigger,
  output int gap_len,
  output int trig_gap,
  output int trig_count,
  output logic shoot_through
);
  int low_run;
  int since_trig;
  // switch pair watches dead gaps and overlap, adc input times conversion starts
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      low_run <= 0;
      gap_len <= 0;
      shoot_through <= 1'b0;
      since_trig <= 0;
      trig_gap <= 0;
      trig_count <= 0;
    end
    else
    begin
      if (pwm_output_a && pwm_output_b)
        shoot_through <= 1'b1;
      low_run <= (pwm_output_a || pwm_output_b) ? 0 : low_run + 1;
      if ((pwm_output_a || pwm_output_b) && low_run > 0)
        gap_len <= low_run;
      since_trig <= adc_trigger ? 1 : since_trig + 1;
      if (adc_trigger)
        trig_gap <= since_trig;
      if (adc_trigger)
        trig_count <= trig_count + 1;
    end
endmodule

// File: verif/tpwm_top_tb_top.sv
`timescale 1ns/1ps
module tpwm_top_tb_top;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] q;
  logic [31:0] dat_o;
  logic ack, out_a, out_b, trig, irq, shoot;
  int gap_len, trig_gap, trig_count;
  int mismatches = 0;
  int checks = 0;
  int seed = 8857;
  int m, k, c, len, lo, hi, seen, bad;
  tpwm_top uut (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .pwm_output_a(out_a),
    .pwm_output_b(out_b), .adc_trigger(trig), .irq(irq));
  tpwm_partner u_far (.sys_clk(sys_clk), .nrst(nrst), .pwm_output_a(out_a), .pwm_output_b(out_b),
    .adc_trigger(trig), .gap_len(gap_len), .trig_gap(trig_gap), .trig_count(trig_count), .shoot_through(shoot));
  // free-running clock
  always #50 sys_clk = ~sys_clk;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] r);
    int n;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      mismatches++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] junk;
    wb(1'b1, a, d, 4'hF, junk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    wb(1'b0, a, 32'h0, 4'hF, r);
  endtask
  task automatic wait_trig(input int n);
    int t0;
    t0 = trig_count;
    for (int i = 0; i < 5000 && trig_count < t0 + n; i++)
      @(posedge sys_clk);
    if (trig_count < t0 + n)
    begin
      mismatches++;
      wrap_up();
    end
  endtask
  // count cycles in which the pair breaks the expected relation
  task automatic watch(input logic comp, output int nbad);
    nbad = 0;
    repeat (50) @(negedge sys_clk);
    repeat (300) @(negedge sys_clk)
      if (comp ? (out_a === out_b) : (out_b !== 1'b0))
        nbad++;
  endtask
  function automatic int trig_period(int p, int kk);
    return (p + 1) * (kk + 1);
  endfunction
  function automatic int dt_cycles(int l, int kk, logic s);
    return s ? (l + 1) * (kk + 1) : l + 1;
  endfunction
  // main sequence
  initial
  begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(tpwm_pkg::OFS_COMPARE, q);
    chk("compare_rst", 32'h0, q);
    rd(tpwm_pkg::OFS_DEADTIME, q);
    chk("deadtime_rst", 32'h0, q);
    rd(8'h70, q);
    chk("unmapped", 32'h0, q);
    wr(tpwm_pkg::OFS_DEADTIME, 32'h0101_0003);
    rd(tpwm_pkg::OFS_DEADTIME, q);
    chk("dt_locked", 32'h0, q);
    wb(1'b1, tpwm_pkg::OFS_COMPARE, 32'hFFFF_FFFF, 4'h3, q);
    wb(1'b1, tpwm_pkg::OFS_COMPARE, 32'h0000_1234, 4'h1, q);
    rd(tpwm_pkg::OFS_COMPARE, q);
    chk("cmp_lanes", 32'h0000_FF34, q);
    wr(tpwm_pkg::OFS_LOCK, 32'(tpwm_pkg::UNLOCK_KEY1));
    wr(tpwm_pkg::OFS_LOCK, 32'(tpwm_pkg::UNLOCK_KEY2));
    wr(tpwm_pkg::OFS_LOCK, 32'(tpwm_pkg::UNLOCK_KEY3));
    wr(tpwm_pkg::OFS_PERIOD, 32'd40);
    for (m = 0; m < 2; m++)
    begin
      k = $random(seed) & 3;
      c = 10 + {$random(seed)} % 21;
      wr(tpwm_pkg::OFS_PRESCALE, k);
      wr(tpwm_pkg::OFS_COMPARE, c);
      wr(tpwm_pkg::OFS_MODE, m);
      wait_trig(3);
      chk("trig_gap", trig_period(40, k), trig_gap);
      rd(tpwm_pkg::OFS_COUNTER, q);
      chk("dir_flag", 32'(m == 0), 32'(q[16]));
      chk("cnt_range", 32'h1, 32'(q[15:0] <= 16'd40));
    end
    wr(tpwm_pkg::OFS_PRESCALE, 32'h0);
    wr(tpwm_pkg::OFS_MODE, 32'h2);
    seen = 0;
    repeat (40)
    begin
      rd(tpwm_pkg::OFS_COUNTER, q);
      seen = seen | (q[16] ? 2 : 1);
    end
    chk("updown_dirs", 32'h3, seen);
    for (m = 0; m < 2; m++)
    begin
      k = $random(seed) & 3;
      len = 1 + {$random(seed)} % 7;
      wr(tpwm_pkg::OFS_PRESCALE, k);
      wr(tpwm_pkg::OFS_MODE, 32'h4);
      wr(tpwm_pkg::OFS_DEADTIME, (m << 24) | 32'h0001_0000 | len);
      rd(tpwm_pkg::OFS_DEADTIME, q);
      chk("dt_rw", (m << 24) | 32'h0001_0000 | len, q);
      wait_trig(2);
      hi = dt_cycles(len, k, m);
      lo = hi - (m ? k : 0);
      chk("dt_gap", 32'h1, 32'(gap_len >= lo && gap_len <= hi));
    end
    wr(tpwm_pkg::OFS_DEADTIME, 32'h0);
    watch(1'b1, bad);
    chk("pair_cmpl", 32'h0, bad);
    wr(tpwm_pkg::OFS_MODE, 32'h0);
    wr(tpwm_pkg::OFS_DEADTIME, 32'h0001_0002);
    watch(1'b0, bad);
    chk("pair_plain", 32'h0, bad);
    wr(tpwm_pkg::OFS_PRESCALE, 32'h3);
    wr(tpwm_pkg::OFS_INT_MASK, 32'h4);
    wait_trig(1);
    repeat (3) @(posedge sys_clk);
    chk("irq_on", 32'h1, irq);
    rd(tpwm_pkg::OFS_INT_STATUS, q);
    chk("irq_status", 32'h1, q[tpwm_pkg::INT_CMP_UP_BIT]);
    repeat (2) @(posedge sys_clk);
    chk("irq_cleared", 32'h0, irq);
    wait_trig(1);
    repeat (3) @(posedge sys_clk);
    chk("irq_again", 32'h1, irq);
    wr(tpwm_pkg::OFS_INT_MASK, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk("irq_masked", 32'h0, irq);
    chk("overlap", 32'h0, shoot);
    wrap_up();
  end
endmodule
